// ### tb_top.sv
`timescale 1ns/1ps
`include "wdk_map.svh"
`default_nettype none
module tb_top;
    logic        sys_clk, resetn, low_speed_rc_clock, mcu_reset, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          mismatches, compares, resets_seen, n_rst, cycles, t0, k, seed;
    logic [7:0]  rel;

    wdk_top wdk_top_inst (.sys_clk, .resetn, .low_speed_rc_clock,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mcu_reset, .irq);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // fast stand-in for the rc oscillator, unrelated in phase
    initial begin
        low_speed_rc_clock = 1'b0;
        forever #330 low_speed_rc_clock = ~low_speed_rc_clock;
    end

    task check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task complete_run;
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bq.push_back(e);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready)
                   || (s_axi_wvalid && !s_axi_wready));
        // a late bready keeps the response standing for a while
        repeat ({$random(seed)} % 3) @(posedge sys_clk);
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat ({$random(seed)} % 3) @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    // results are compared against the oldest note as they appear
    always @(posedge sys_clk) begin
        cycles++;
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (mcu_reset) resets_seen++;
        if (cycles == 90000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        seed = 41;
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`WDK_OFF_CTRL, 34'h50);
        rd(`WDK_OFF_RELOAD, 34'h0);
        rd(`WDK_OFF_ARM, 34'h0);
        rd(`WDK_OFF_RSTFLG, 34'h0);
        rd(8'h20, 34'h200000000);
        wr(8'h24, 32'h1, `WDK_RESP_SLVERR);
        // every key code, with the fast clock selected
        for (k = 0; k < 32; k++) begin
            wr(`WDK_OFF_CTRL, {24'h0, k[4:0], 3'h1}, `WDK_RESP_OKAY);
            if (k[4:0] == `WDK_KEY_ENABLE || k[4:0] == `WDK_KEY_DISABLE)
                rd(`WDK_OFF_CTRL, {26'h0, k[4:0], 3'h1});
            else begin
                rd(`WDK_OFF_CTRL, 34'h50);
                n_rst++;
            end
        end
        repeat (4) @(posedge sys_clk);
        check(resets_seen, n_rst);
        rd(`WDK_OFF_RSTFLG, 34'h2);
        rd(`WDK_OFF_ISTAT, 34'h2);
        check({33'h0, irq}, 34'h0);
        wr(`WDK_OFF_IEN, 32'h2, `WDK_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        check({33'h0, irq}, 34'h1);
        wr(`WDK_OFF_ICLR, 32'h2, `WDK_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        check({33'h0, irq}, 34'h0);
        // commit alone, and an arm broken by another write
        rel = 8'($random(seed));
        wr(`WDK_OFF_COMMIT, 32'h1, `WDK_RESP_OKAY);
        wr(`WDK_OFF_ARM, 32'h1, `WDK_RESP_OKAY);
        wr(`WDK_OFF_RELOAD, {24'h0, rel}, `WDK_RESP_OKAY);
        wr(`WDK_OFF_COMMIT, 32'h1, `WDK_RESP_OKAY);
        n_rst += 2;
        rd(`WDK_OFF_RELOAD, {26'h0, rel});
        rd(`WDK_OFF_RSTFLG, 34'h1);
        rd(`WDK_OFF_ISTAT, 34'h4);
        wr(`WDK_OFF_RSTFLG, 32'h0, `WDK_RESP_OKAY);
        rd(`WDK_OFF_RSTFLG, 34'h0);
        wr(`WDK_OFF_ARM, 32'h1, `WDK_RESP_OKAY);
        wr(`WDK_OFF_COMMIT, 32'h1, `WDK_RESP_OKAY);
        rd(`WDK_OFF_ARM, 34'h0);
        rd(`WDK_OFF_COMMIT, 34'h0);
        // the refresh dropped the arm, so a lone commit must reset
        wr(`WDK_OFF_COMMIT, 32'h1, `WDK_RESP_OKAY);
        n_rst++;
        repeat (2) @(posedge sys_clk);
        check(resets_seen, n_rst);
        // shortest timeout: 256 counts of 256 clocks each
        wr(`WDK_OFF_CTRL, 32'h51, `WDK_RESP_OKAY);
        wr(`WDK_OFF_RELOAD, 32'hFF, `WDK_RESP_OKAY);
        wr(`WDK_OFF_ARM, 32'h1, `WDK_RESP_OKAY);
        wr(`WDK_OFF_COMMIT, 32'h1, `WDK_RESP_OKAY);
        t0 = cycles;
        n_rst++;
        while (resets_seen < n_rst) @(posedge sys_clk);
        k = cycles - t0;
        check({33'h0, k >= 65500}, 34'h1);
        check({33'h0, k <= 65580}, 34'h1);
        rd(`WDK_OFF_RSTFLG, 34'h1);
        rd(`WDK_OFF_ISTAT, 34'h5);
        rd(`WDK_OFF_CTRL, 34'h50);
        rd(`WDK_OFF_RELOAD, 34'hFF);
        check(resets_seen, n_rst);
        complete_run();
    end
endmodule : tb_top

bind wdk_top wdk_monitor wdk_monitor_inst (.sys_clk, .resetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mcu_reset);
`default_nettype wire

// ### wdk_div16.sv
`timescale 1ns/1ps
`include "wdk_map.svh"
`default_nettype none
module wdk_div16 (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // restart the division
    input  wire logic clr,
    // ticks in and out
    input  wire logic tick_in,
    output var  logic tick_out
);
    logic [3:0] cnt_r;
    wire        last = (cnt_r == `WDK_DIV_LAST);

    always_ff @(posedge sys_clk) begin
        if (!resetn || clr) begin
            cnt_r    <= 4'h0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && last;
            if (tick_in) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule : wdk_div16
`default_nettype wire

// ### wdk_map.svh
// How it works
// - the watchdog source is either the low-speed rc clock or sys/16.
// - select 0 picks the low-speed rc clock, 1 picks the system clock/16.
// - the selected source is divided by sixteen before the counter.
// - a 16-bit counter issues a device reset when it overflows.
// - the counter is a low and a high byte that software cannot reach.
// - key 10101 disables, 01010 enables, any other key resets at once.
// - after power-on the key holds the enable code, so counting starts.
// - a commit that does not directly follow an arm causes a reset.
// - a completed refresh clears the arm and commit bits by itself.
// - a refresh loads the reload value into the counter high byte.
// - a larger reload value gives a shorter timeout, zero the longest.
// - a reset caused by an illegal key sets the control-key flag.
// - overflow sets the watchdog flag; only software clears it.
`ifndef WDK_MAP_SVH
`define WDK_MAP_SVH

// register byte offsets
`define WDK_OFF_CTRL    8'h00
`define WDK_OFF_RELOAD  8'h04
`define WDK_OFF_ARM     8'h08
`define WDK_OFF_COMMIT  8'h0C
`define WDK_OFF_RSTFLG  8'h10
`define WDK_OFF_ISTAT   8'h14
`define WDK_OFF_ICLR    8'h18
`define WDK_OFF_IEN     8'h1C

// key codes and reset values
`define WDK_KEY_DISABLE 5'h15
`define WDK_KEY_ENABLE  5'h0A
`define WDK_CTRL_RESET  8'h50
`define WDK_RELOAD_RST  8'h00
`define WDK_SEL_LOW_SPEED_RC_CLOCK    1'h0
`define WDK_SEL_SYS16   1'h1

// counter figures
`define WDK_DIV_LAST    4'hF
`define WDK_CNT_LAST    16'hFFFF
`define WDK_BYTE_ZERO   8'h00

// field positions
`define WDK_ARM_BIT     0
`define WDK_COMMIT_BIT  0
`define WDK_RF_WDT      0
`define WDK_RF_KEY      1
`define WDK_EV_W        3
`define WDK_KEY_MSB     7
`define WDK_KEY_LSB     3
`define WDK_SEL_BIT     0
`define WDK_BYTE_MSB    7

// bus answers
`define WDK_RESP_OKAY   2'h0
`define WDK_RESP_SLVERR 2'h2
`define WDK_WORD_ZERO   32'h0000_0000

`endif

// ### wdk_monitor.sv
`timescale 1ns/1ps
`include "wdk_map.svh"
`default_nettype none
module wdk_monitor (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // reset request
    input wire logic        mcu_reset
);
    logic wr_go;
    logic key_ok;
    logic arm_r;
    logic arm_nxt;

    assign wr_go = s_axi_awvalid && s_axi_awready
                && s_axi_wvalid && s_axi_wready;
    assign key_ok = s_axi_wdata[7:3] == `WDK_KEY_ENABLE
                 || s_axi_wdata[7:3] == `WDK_KEY_DISABLE;
    // any write other than an arm, or a device reset, cancels a pending arm
    assign arm_nxt = wr_go ? (s_axi_awaddr == `WDK_OFF_ARM && s_axi_wdata[0])
                           : arm_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn || mcu_reset) arm_r <= 1'b0;
        else arm_r <= arm_nxt;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_reset_one_cycle: assert property (mcu_reset |=> !mcu_reset)
        else $error("reset pulse too long");
    a_bad_key_reset: assert property (
        wr_go && s_axi_awaddr == `WDK_OFF_CTRL && !key_ok
        |-> ##[1:3] mcu_reset) else $error("bad key kept running");
    a_good_key_quiet: assert property (
        wr_go && s_axi_awaddr == `WDK_OFF_CTRL && key_ok
        |-> ##1 !mcu_reset [*3]) else $error("good key reset");
    a_stray_commit: assert property (
        wr_go && s_axi_awaddr == `WDK_OFF_COMMIT && s_axi_wdata[0] && !arm_r
        |-> ##[1:3] mcu_reset) else $error("stray commit ignored");
    a_refresh_quiet: assert property (
        wr_go && s_axi_awaddr == `WDK_OFF_COMMIT && s_axi_wdata[0] && arm_r
        |-> ##1 !mcu_reset [*3]) else $error("refresh caused reset");
    a_unmapped_err: assert property (wr_go && s_axi_awaddr > `WDK_OFF_IEN
        |-> ##[1:3] s_axi_bvalid && s_axi_bresp == `WDK_RESP_SLVERR)
        else $error("unmapped write accepted");
endmodule : wdk_monitor
`default_nettype wire

// ### wdk_pkg.sv
package wdk_pkg;

    typedef struct packed {
        logic [4:0] key;
        logic [1:0] unused;
        logic       sel;
    } wdk_ctrl_s;

    // event bits, shared by status, clear and enable registers
    typedef struct packed {
        logic seq;
        logic key;
        logic ovf;
    } wdk_ev_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } wdk_wr_s;

    typedef enum logic [1:0] {
        WDK_IDLE  = 2'b01,
        WDK_ARMED = 2'b10
    } wdk_seq_e;

endpackage : wdk_pkg

// ### wdk_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wdk_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // level from another domain
    input  wire logic d,
    output var  logic q
);
    logic meta_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : wdk_sync
`default_nettype wire

// ### wdk_top.sv
`timescale 1ns/1ps
`include "wdk_map.svh"
`default_nettype none
module wdk_top
    import wdk_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // low-speed rc oscillator, asynchronous to sys_clk
    input  wire logic        low_speed_rc_clock,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // axi4-lite read data
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device reset request and interrupt
    output var  logic        mcu_reset,
    output var  logic        irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    wdk_ctrl_s   ctrl_r;
    logic [7:0]  reload_r;
    logic [7:0]  counter_high_byte_r;
    logic [7:0]  counter_low_byte_r;
    wdk_seq_e    seq_r;
    wdk_seq_e    seq_nxt;
    logic        wdt_flag_r;
    logic        key_flag_r;
    wdk_ev_s     istat_r;
    wdk_ev_s     ien_r;
    logic        low_speed_rc_clock_d_r;

    // write channel holding
    logic        aw_full_r;
    logic        w_full_r;
    wdk_wr_s     wr_r;

    // ------------------------------------------------------------------
    // source clocks
    // ------------------------------------------------------------------
    logic low_speed_rc_clock_s;
    logic sys16_tick;
    logic cnt_tick;

    // the rc clock is only ever seen through the synchroniser
    wdk_sync u_low_speed_rc_clock_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (low_speed_rc_clock),
        .q       (low_speed_rc_clock_s)
    );

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            low_speed_rc_clock_d_r <= 1'b0;
        end else begin
            low_speed_rc_clock_d_r <= low_speed_rc_clock_s;
        end
    end

    wire low_speed_rc_clock_rise = low_speed_rc_clock_s && !low_speed_rc_clock_d_r;

    // free running sys/16 source
    wdk_div16 u_sys_div (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clr      (1'b0),
        .tick_in  (1'b1),
        .tick_out (sys16_tick)
    );

    wire sel_sys16 = (ctrl_r.sel == `WDK_SEL_SYS16);
    wire src_tick  = sel_sys16 ? sys16_tick : low_speed_rc_clock_rise;

    // ------------------------------------------------------------------
    // key decode
    // ------------------------------------------------------------------
    wire key_enable  = (ctrl_r.key == `WDK_KEY_ENABLE);

    // ------------------------------------------------------------------
    // bus write decode
    // ------------------------------------------------------------------
    wire wr_fire     = aw_full_r && w_full_r && !s_axi_bvalid;
    wire wr_lane0    = wr_fire && wr_r.strb[0];
    wire hit_ctrl    = (wr_r.addr == `WDK_OFF_CTRL);
    wire hit_reload  = (wr_r.addr == `WDK_OFF_RELOAD);
    wire hit_arm     = (wr_r.addr == `WDK_OFF_ARM);
    wire hit_commit  = (wr_r.addr == `WDK_OFF_COMMIT);
    wire hit_rstflg  = (wr_r.addr == `WDK_OFF_RSTFLG);
    wire hit_istat   = (wr_r.addr == `WDK_OFF_ISTAT);
    wire hit_iclr    = (wr_r.addr == `WDK_OFF_ICLR);
    wire hit_ien     = (wr_r.addr == `WDK_OFF_IEN);
    wire wr_mapped   = hit_ctrl || hit_reload || hit_arm || hit_commit ||
                       hit_rstflg || hit_istat || hit_iclr || hit_ien;

    wire [4:0] new_key = wr_r.data[`WDK_KEY_MSB:`WDK_KEY_LSB];
    wire       key_wr  = wr_lane0 && hit_ctrl;
    wire       key_ok  = (new_key == `WDK_KEY_ENABLE) ||
                         (new_key == `WDK_KEY_DISABLE);
    wire       key_bad = key_wr && !key_ok;

    wire arm_wr    = wr_lane0 && hit_arm &&
                     wr_r.data[`WDK_ARM_BIT];
    wire commit_wr = wr_lane0 && hit_commit &&
                     wr_r.data[`WDK_COMMIT_BIT];

    // the "next instruction" is the next register write of any kind
    wire refresh   = commit_wr && (seq_r == WDK_ARMED);
    wire seq_bad   = commit_wr && (seq_r == WDK_IDLE);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    wire wdt_run   = key_enable;
    wire [15:0] count = {counter_high_byte_r, counter_low_byte_r};
    wire ovf       = cnt_tick && (count == `WDK_CNT_LAST);

    // any of these restarts the device; control, sequence, prescaler and counter fall back to reset state
    wire wdt_reset = ovf || seq_bad;
    wire any_reset = wdt_reset || key_bad;

    // prescaler restarts with every refresh so a timeout is whole periods
    wdk_div16 u_pre_div (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clr      (refresh || any_reset),
        .tick_in  (src_tick && wdt_run),
        .tick_out (cnt_tick)
    );

    // counter bytes have no bus path at all
    always_ff @(posedge sys_clk) begin
        if (!resetn || any_reset) begin
            counter_high_byte_r <= `WDK_BYTE_ZERO;
            counter_low_byte_r  <= `WDK_BYTE_ZERO;
        end else if (refresh) begin
            counter_high_byte_r <= reload_r;
            counter_low_byte_r  <= `WDK_BYTE_ZERO;
        end else if (cnt_tick) begin
            {counter_high_byte_r, counter_low_byte_r} <= count + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // refresh sequence
    // ------------------------------------------------------------------
    always_comb begin
        seq_nxt = seq_r;
        unique case (seq_r)
            WDK_IDLE: begin
                if (arm_wr) begin
                    seq_nxt = WDK_ARMED;
                end
            end
            WDK_ARMED: begin
                // any write ends the armed window; arm again re-arms
                if (wr_fire) begin
                    seq_nxt = arm_wr ? WDK_ARMED : WDK_IDLE;
                end
            end
            default: seq_nxt = WDK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || any_reset) begin
            seq_r <= WDK_IDLE;
        end else begin
            seq_r <= seq_nxt;
        end
    end

    // ------------------------------------------------------------------
    // control and reload
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn || any_reset) begin
            ctrl_r <= wdk_ctrl_s'(`WDK_CTRL_RESET);
        end else if (key_wr) begin
            ctrl_r.key <= new_key;
            ctrl_r.sel <= wr_r.data[`WDK_SEL_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reload_r <= `WDK_RELOAD_RST;
        end else if (wr_lane0 && hit_reload) begin
            reload_r <= wr_r.data[`WDK_BYTE_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // reset indication flags; a set wins over a clear
    // ------------------------------------------------------------------
    wire rstflg_wr = wr_lane0 && hit_rstflg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wdt_flag_r <= 1'b0;
            key_flag_r <= 1'b0;
        end else begin
            if (wdt_reset) begin
                wdt_flag_r <= 1'b1;
            end else if (rstflg_wr && !wr_r.data[`WDK_RF_WDT]) begin
                wdt_flag_r <= 1'b0;
            end
            // hardware only: cleared when a different reset type occurs
            if (key_bad) begin
                key_flag_r <= 1'b1;
            end else if (wdt_reset) begin
                key_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    wdk_ev_s ev;
    assign ev.ovf = ovf;
    assign ev.key = key_bad;
    assign ev.seq = seq_bad;

    wire [`WDK_EV_W-1:0] iclr_bits =
        (wr_lane0 && hit_iclr) ? wr_r.data[`WDK_EV_W-1:0] : 3'h0;

    genvar gi;
    generate
        for (gi = 0; gi < `WDK_EV_W; gi++) begin : g_ev
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    istat_r[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    istat_r[gi] <= 1'b1;
                end else if (iclr_bits[gi]) begin
                    istat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ien_r <= '0;
        end else if (wr_lane0 && hit_ien) begin
            ien_r <= wdk_ev_s'(wr_r.data[`WDK_EV_W-1:0]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq       <= 1'b0;
            mcu_reset <= 1'b0;
        end else begin
            irq       <= |(istat_r & ien_r);
            mcu_reset <= any_reset;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write side: address and data taken in either order
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            wr_r          <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `WDK_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r   <= 1'b1;
                wr_r.addr   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r    <= 1'b1;
                wr_r.data   <= s_axi_wdata;
                wr_r.strb   <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `WDK_RESP_OKAY
                                          : `WDK_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read side
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic        rd_mapped;

    always_comb begin
        rd_word   = `WDK_WORD_ZERO;
        rd_mapped = 1'b1;
        unique case (s_axi_araddr)
            `WDK_OFF_CTRL:   rd_word[`WDK_BYTE_MSB:0] = ctrl_r;
            `WDK_OFF_RELOAD: rd_word[`WDK_BYTE_MSB:0] = reload_r;
            `WDK_OFF_ARM:    rd_word      = `WDK_WORD_ZERO;
            `WDK_OFF_COMMIT: rd_word      = `WDK_WORD_ZERO;
            `WDK_OFF_RSTFLG: begin
                rd_word[`WDK_RF_WDT] = wdt_flag_r;
                rd_word[`WDK_RF_KEY] = key_flag_r;
            end
            `WDK_OFF_ISTAT:  rd_word[`WDK_EV_W-1:0] = istat_r;
            `WDK_OFF_ICLR:   rd_word      = `WDK_WORD_ZERO;
            `WDK_OFF_IEN:    rd_word[`WDK_EV_W-1:0] = ien_r;
            default:         rd_mapped    = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `WDK_WORD_ZERO;
            s_axi_rresp   <= `WDK_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid &&
                             !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_mapped ? `WDK_RESP_OKAY
                                          : `WDK_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : wdk_top
`default_nettype wire
